// ==== tpw_consts.vh ====
// Purpose: Constants for the 16-bit timer PWM waveform block
// Assumes: One clock, synchronous high reset
// Notes:   Timing counts are in I/O clock cycles
`ifndef TPW_CONSTS_VH
`define TPW_CONSTS_VH
// ==========================================================
// Waveform mode codes
`define TPW_WM_PC8     4'h1
`define TPW_WM_PC9     4'h2
`define TPW_WM_PC10    4'h3
`define TPW_WM_FP8     4'h5
`define TPW_WM_FP9     4'h6
`define TPW_WM_FP10    4'h7
`define TPW_WM_PFC_ICR 4'h8
`define TPW_WM_PFC_OCA 4'h9
`define TPW_WM_PC_ICR  4'ha
`define TPW_WM_PC_OCA  4'hb
`define TPW_WM_FP_ICR  4'he
`define TPW_WM_FP_OCA  4'hf
// ==========================================================
// Fixed TOP values
`define TPW_TOP8       16'h00ff
`define TPW_TOP9       16'h01ff
`define TPW_TOP10      16'h03ff
`define TPW_TOP_MAX    16'hffff
// ==========================================================
// Output mode codes
`define TPW_OM_OFF     2'h0
`define TPW_OM_TOGGLE  2'h1
`define TPW_OM_NONINV  2'h2
`define TPW_OM_INV     2'h3
// ==========================================================
// Reset values
`define TPW_RST_COUNT  16'h0000
`define TPW_RST_CMP    16'h0000
`endif

// ==== tpw_prescale.v ====
// Purpose: Timer tick enable from I/O clock
// Assumes: Select 0 stops, 1..5 divide by 1,8,64,256,1024
// Notes:   Tick is a one-cycle pulse, high every cycle at divide by 1
`timescale 1ns/1ns
module tpw_prescale (
  input  wire       mclk,
  input  wire       srst,
  input  wire       ce,
  input  wire [2:0] clock_select,
  output reg        tick
);
  reg [9:0] div;
  reg       next_tick;
  // ========================================================
  // Divider tap select
  always @* begin
    case (clock_select)
      3'h1:    next_tick = 1'b1;
      3'h2:    next_tick = (div[2:0] == 3'h7);
      3'h3:    next_tick = (div[5:0] == 6'h3f);
      3'h4:    next_tick = (div[7:0] == 8'hff);
      3'h5:    next_tick = (div == 10'h3ff);
      default: next_tick = 1'b0;
    endcase
  end
  always @(posedge mclk) begin
    if (srst) begin
      div  <= 10'h000;
      tick <= 1'b0;
    end else if (ce) begin
      div  <= div + 10'h001;
      tick <= next_tick;
    end
  end
endmodule // tpw_prescale

// ==== tpw_channel.v ====
// Purpose: One compare channel with buffer and waveform output
// Assumes: Strobes from counter core, one cycle each
// Notes:   Output register holds level even when pin is off
`timescale 1ns/1ns
`include "tpw_consts.vh"
module tpw_channel (
  input  wire        mclk,
  input  wire        srst,
  input  wire        ce,
  input  wire        tick,
  input  wire [15:0] count_value,
  input  wire [15:0] top_value,
  input  wire        count_down,
  input  wire        at_top,
  input  wire        dual_slope,
  input  wire        toggle_ok,
  input  wire        load_now,
  input  wire [15:0] fixed_mask,
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  input  wire [1:0]  output_mode,
  input  wire        pin_direction_out,
  output reg  [15:0] compare_active,
  output reg         match,
  output reg         wave,
  output reg         pin_out,
  output reg         pin_oe
);
  reg  [15:0] buffer;
  reg         next_wave;
  wire        hit = tick && (count_value == compare_active);
  wire        cap = (compare_active == top_value);
  // ========================================================
  // Waveform decision
  always @* begin
    next_wave = wave;
    if (tick) begin
      case (output_mode)
        `TPW_OM_TOGGLE: begin
          if (toggle_ok && hit)
            next_wave = ~wave;
        end
        `TPW_OM_NONINV, `TPW_OM_INV: begin
          if (dual_slope) begin
            if (hit)
              next_wave = (count_down || cap) ^ output_mode[0];
            if (compare_active == 16'h0000)
              next_wave = output_mode[0];
          end else begin
            if (hit && !cap)
              next_wave = output_mode[0];
            if (at_top)
              next_wave = ~output_mode[0];
            if (at_top && cap)
              next_wave = output_mode[0];
          end
        end
        default: next_wave = wave;
      endcase
    end
  end
  // ========================================================
  // Buffer, active compare and output register
  always @(posedge mclk) begin
    if (srst) begin
      buffer         <= `TPW_RST_CMP;
      compare_active <= `TPW_RST_CMP;
      match          <= 1'b0;
      wave           <= 1'b0;
      pin_out        <= 1'b0;
      pin_oe         <= 1'b0;
    end else if (ce) begin
      if (wr_en)
        buffer <= wr_data & fixed_mask;
      if (load_now)
        compare_active <= buffer;
      match   <= hit;
      wave    <= next_wave;
      pin_out <= next_wave;
      pin_oe  <= pin_direction_out && (output_mode != `TPW_OM_OFF)
                 && (output_mode != `TPW_OM_TOGGLE || toggle_ok);
    end
  end
endmodule // tpw_channel

// ==== tpw_top.v ====
// Purpose: 16-bit timer PWM waveform generator, two channels
// Assumes: Software keeps TOP in range and above compares
// Notes:   Flags are sticky, cleared by one-cycle clear pulses
`timescale 1ns/1ns
`include "tpw_consts.vh"
module tpw_top (
  input  wire        mclk,
  input  wire        srst,
  input  wire        ce,
  input  wire [3:0]  waveform_mode,
  input  wire [2:0]  clock_select,
  input  wire [1:0]  output_mode_a,
  input  wire [1:0]  output_mode_b,
  input  wire        pin_direction_out_a,
  input  wire        pin_direction_out_b,
  input  wire        write_a,
  input  wire        write_b,
  input  wire        write_capture,
  input  wire [15:0] write_data,
  input  wire        clear_overflow,
  input  wire        clear_match_a,
  input  wire        clear_match_b,
  input  wire        clear_capture,
  output reg  [15:0] count_value,
  output reg         count_down,
  output reg  [15:0] capture_value,
  output reg         overflow_flag,
  output reg         match_flag_a,
  output reg         match_flag_b,
  output reg         capture_flag,
  output wire [15:0] compare_value_a,
  output wire [15:0] compare_value_b,
  output wire        compare_out_a,
  output wire        compare_out_b,
  output wire        compare_oe_a,
  output wire        compare_oe_b
);
  wire        tick;
  wire        match_a;
  wire        match_b;
  wire        wave_a;
  wire        wave_b;
  reg  [15:0] top_value;
  reg  [15:0] fixed_mask;
  reg         dual_slope;
  reg         pfc_mode;
  reg         pwm_mode;
  reg         top_from_a;
  reg         top_from_cap;
  reg  [15:0] next_count;
  reg         next_down;
  wire        at_top  = tick && pwm_mode && (count_value == top_value);
  wire        at_zero = tick && dual_slope && (count_value == 16'h0000)
                        && count_down;
  wire        load_now = pfc_mode ? at_zero : at_top;
  wire        toggle_ok = top_from_a;
  // ========================================================
  // Mode decode
  always @* begin
    top_value    = `TPW_TOP_MAX;
    fixed_mask   = `TPW_TOP_MAX;
    dual_slope   = 1'b0;
    pfc_mode     = 1'b0;
    pwm_mode     = 1'b1;
    top_from_a   = 1'b0;
    top_from_cap = 1'b0;
    case (waveform_mode)
      `TPW_WM_FP8: begin
        top_value  = `TPW_TOP8;
        fixed_mask = `TPW_TOP8;
      end
      `TPW_WM_FP9: begin
        top_value  = `TPW_TOP9;
        fixed_mask = `TPW_TOP9;
      end
      `TPW_WM_FP10: begin
        top_value  = `TPW_TOP10;
        fixed_mask = `TPW_TOP10;
      end
      `TPW_WM_FP_ICR: begin
        top_value    = capture_value;
        top_from_cap = 1'b1;
      end
      `TPW_WM_FP_OCA: begin
        top_value  = compare_value_a;
        top_from_a = 1'b1;
      end
      `TPW_WM_PC8: begin
        top_value  = `TPW_TOP8;
        fixed_mask = `TPW_TOP8;
        dual_slope = 1'b1;
      end
      `TPW_WM_PC9: begin
        top_value  = `TPW_TOP9;
        fixed_mask = `TPW_TOP9;
        dual_slope = 1'b1;
      end
      `TPW_WM_PC10: begin
        top_value  = `TPW_TOP10;
        fixed_mask = `TPW_TOP10;
        dual_slope = 1'b1;
      end
      `TPW_WM_PC_ICR: begin
        top_value    = capture_value;
        top_from_cap = 1'b1;
        dual_slope   = 1'b1;
      end
      `TPW_WM_PC_OCA: begin
        top_value  = compare_value_a;
        top_from_a = 1'b1;
        dual_slope = 1'b1;
      end
      `TPW_WM_PFC_ICR: begin
        top_value    = capture_value;
        top_from_cap = 1'b1;
        dual_slope   = 1'b1;
        pfc_mode     = 1'b1;
      end
      `TPW_WM_PFC_OCA: begin
        top_value  = compare_value_a;
        top_from_a = 1'b1;
        dual_slope = 1'b1;
        pfc_mode   = 1'b1;
      end
      default: pwm_mode = 1'b0;
    endcase
  end
  // ========================================================
  // Counter sequence
  always @* begin
    next_count = count_value;
    next_down  = count_down;
    if (tick) begin
      if (!pwm_mode) begin
        next_count = count_value + 16'h0001;
        next_down  = 1'b0;
      end else if (!dual_slope) begin
        next_down = 1'b0;
        if (count_value == top_value)
          next_count = 16'h0000;
        else
          next_count = count_value + 16'h0001;
      end else if (count_value == top_value) begin
        next_down  = 1'b1;
        next_count = (top_value == 16'h0000) ? 16'h0000
                     : count_value - 16'h0001;
      end else if (count_down && count_value == 16'h0000) begin
        next_down  = 1'b0;
        next_count = 16'h0001;
      end else if (count_down) begin
        next_count = count_value - 16'h0001;
      end else begin
        next_count = count_value + 16'h0001;
      end
    end
  end
  always @(posedge mclk) begin
    if (srst) begin
      count_value   <= `TPW_RST_COUNT;
      count_down    <= 1'b0;
      capture_value <= `TPW_RST_CMP;
      overflow_flag <= 1'b0;
      match_flag_a  <= 1'b0;
      match_flag_b  <= 1'b0;
      capture_flag  <= 1'b0;
    end else if (ce) begin
      count_value <= next_count;
      count_down  <= next_down;
      if (write_capture)
        capture_value <= write_data;
      // Set wins over clear
      if (dual_slope ? at_zero : at_top)
        overflow_flag <= 1'b1;
      else if (clear_overflow)
        overflow_flag <= 1'b0;
      if (match_a || (at_top && top_from_a))
        match_flag_a <= 1'b1;
      else if (clear_match_a)
        match_flag_a <= 1'b0;
      if (match_b)
        match_flag_b <= 1'b1;
      else if (clear_match_b)
        match_flag_b <= 1'b0;
      if (at_top && top_from_cap)
        capture_flag <= 1'b1;
      else if (clear_capture)
        capture_flag <= 1'b0;
    end
  end
  // ========================================================
  // Submodules
  tpw_prescale u_prescale (
    .mclk         (mclk),
    .srst         (srst),
    .ce           (ce),
    .clock_select (clock_select),
    .tick         (tick)
  );
  tpw_channel u_chan_a (
    .mclk              (mclk),
    .srst              (srst),
    .ce                (ce),
    .tick              (tick),
    .count_value       (count_value),
    .top_value         (top_value),
    .count_down        (count_down),
    .at_top            (at_top),
    .dual_slope        (dual_slope),
    .toggle_ok         (toggle_ok),
    .load_now          (load_now),
    .fixed_mask        (fixed_mask),
    .wr_en             (write_a),
    .wr_data           (write_data),
    .output_mode       (output_mode_a),
    .pin_direction_out (pin_direction_out_a),
    .compare_active    (compare_value_a),
    .match             (match_a),
    .wave              (wave_a),
    .pin_out           (compare_out_a),
    .pin_oe            (compare_oe_a)
  );
  tpw_channel u_chan_b (
    .mclk              (mclk),
    .srst              (srst),
    .ce                (ce),
    .tick              (tick),
    .count_value       (count_value),
    .top_value         (top_value),
    .count_down        (count_down),
    .at_top            (at_top),
    .dual_slope        (dual_slope),
    .toggle_ok         (1'b0),
    .load_now          (load_now),
    .fixed_mask        (fixed_mask),
    .wr_en             (write_b),
    .wr_data           (write_data),
    .output_mode       (output_mode_b),
    .pin_direction_out (pin_direction_out_b),
    .compare_active    (compare_value_b),
    .match             (match_b),
    .wave              (wave_b),
    .pin_out           (compare_out_b),
    .pin_oe            (compare_oe_b)
  );
endmodule // tpw_top

// ==== tpw_properties.sv ====
// Purpose: Port assertions for the timer PWM block
// Assumes: Bound to tpw_top, one clock domain
// Notes:   Checks rest for one edge after each reset
`timescale 1ns/1ns
module tpw_properties (
  input wire        mclk,
  input wire        srst,
  input wire [3:0]  waveform_mode,
  input wire [2:0]  clock_select,
  input wire [1:0]  output_mode_a,
  input wire        pin_direction_out_a,
  input wire [15:0] count_value,
  input wire        count_down,
  input wire        overflow_flag,
  input wire        match_flag_a,
  input wire [15:0] compare_value_a,
  input wire        compare_out_a,
  input wire        compare_oe_a
);
  // ==========================================================
  // Helpers
  reg       rs_d;
  reg [5:0] prev;
  wire      st  = (prev == {waveform_mode, output_mode_a});
  wire      m5  = st && (waveform_mode == 4'h5);
  wire      m1  = st && (waveform_mode == 4'h1);
  wire      m89 = st && (waveform_mode[3:1] == 3'h4);
  wire      om2 = (output_mode_a == 2'h2);
  always @(posedge mclk) begin
    rs_d <= srst;
    prev <= {waveform_mode, output_mode_a};
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst || rs_d);
  // ==========================================================
  // Properties
  property p_fast_step;
    m5 && $changed(count_value) |-> count_value == $past(count_value) + 16'h0001
      || (count_value == 16'h0000 && $past(count_value) == 16'h00ff);
  endproperty
  a_fast_step: assert property (p_fast_step) else $error("fast step");
  property p_fast_rise;
    m5 && om2 && $rose(compare_out_a) |-> $past(count_value) == 16'h00ff;
  endproperty
  a_fast_rise: assert property (p_fast_rise) else $error("fast rise");
  property p_fast_fall;
    m5 && om2 && $fell(compare_out_a) |->
      $past(count_value) == $past(compare_value_a);
  endproperty
  a_fast_fall: assert property (p_fast_fall) else $error("fast fall");
  property p_fast_load;
    m5 && $changed(compare_value_a) |-> $past(count_value) == 16'h00ff;
  endproperty
  a_fast_load: assert property (p_fast_load) else $error("fast load");
  property p_pc_top;
    m1 && clock_select == 3'h1 && $past(count_value) == 16'h00fe
      && count_value == 16'h00ff |=> count_value == 16'h00fe;
  endproperty
  a_pc_top: assert property (p_pc_top) else $error("top hold");
  property p_pc_out;
    m1 && om2 && compare_value_a > 16'h0000 && compare_value_a < 16'h00ff
      && $changed(compare_out_a) |-> compare_out_a == $past(count_down);
  endproperty
  a_pc_out: assert property (p_pc_out) else $error("slope level");
  property p_pc_ovf;
    m1 && $rose(overflow_flag) |-> $past(count_value) <= 16'h0001;
  endproperty
  a_pc_ovf: assert property (p_pc_ovf) else $error("bottom flag");
  property p_pc_load;
    m1 && $changed(compare_value_a) |-> $past(count_value) == 16'h00ff;
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("top load");
  property p_pfc_load;
    m89 && $changed(compare_value_a) |->
      count_value == 16'h0000 || $past(count_value) == 16'h0000;
  endproperty
  a_pfc_load: assert property (p_pfc_load) else $error("bottom load");
  property p_match;
    $rose(match_flag_a) |-> $past(count_value) == $past(compare_value_a)
      || $past(count_value, 2) == $past(compare_value_a, 2);
  endproperty
  a_match: assert property (p_match) else $error("match flag");
  property p_oe;
    !pin_direction_out_a && !$past(pin_direction_out_a) |-> !compare_oe_a;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable");
endmodule // tpw_properties

bind tpw_top tpw_properties tpw_properties_i (
  .mclk(mclk), .srst(srst), .waveform_mode(waveform_mode),
  .clock_select(clock_select), .output_mode_a(output_mode_a),
  .pin_direction_out_a(pin_direction_out_a), .count_value(count_value),
  .count_down(count_down), .overflow_flag(overflow_flag),
  .match_flag_a(match_flag_a), .compare_value_a(compare_value_a),
  .compare_out_a(compare_out_a), .compare_oe_a(compare_oe_a)
);

// ==== tpw_load.sv ====
// Purpose: Load on one compare pin, measures period and high time
// Assumes: Pin pulled low when not driven
// Notes:   Counts in I/O clock cycles
`timescale 1ns/1ns
module tpw_load (
  input  wire        mclk,
  input  wire        pin_out,
  input  wire        pin_oe,
  output wire        level,
  output reg  [15:0] rises,
  output reg  [15:0] period,
  output reg  [15:0] high_time
);
  reg [15:0] since;
  reg [15:0] hi_run;
  reg        last;
  assign level = pin_oe & pin_out;
  initial begin
    rises = 16'h0000;
    period = 16'h0000;
    high_time = 16'h0000;
    since = 16'h0000;
    hi_run = 16'h0000;
    last = 1'b0;
  end
  always @(posedge mclk) begin
    last <= level;
    since <= since + 16'h0001;
    hi_run <= level ? hi_run + 16'h0001 : 16'h0000;
    if (level && !last) begin
      rises <= rises + 16'h0001;
      period <= since + 16'h0001;
      since <= 16'h0000;
      hi_run <= 16'h0001;
    end
    if (!level && last)
      high_time <= hi_run;
  end
endmodule // tpw_load

// ==== tb.sv ====
// Purpose: Self-checking bench for the timer PWM block
// Assumes: Inputs driven on the falling edge
// Notes:   Each scenario restarts the block with a reset
`timescale 1ns/1ns
module tb;
  reg         mclk = 1'b0;
  reg         srst = 1'b1;
  reg  [3:0]  mode = 4'h0;
  reg  [2:0]  sel = 3'h0;
  reg  [1:0]  om_a = 2'h0;
  reg  [1:0]  om_b = 2'h0;
  reg         dir_a = 1'b1;
  reg  [2:0]  wr_en = 3'h0;
  reg  [15:0] wdata = 16'h0000;
  reg         clr_cap = 1'b0;
  wire [15:0] cnt;
  wire [15:0] cmp_a;
  wire [15:0] cmp_b;
  wire [15:0] cap_v;
  wire        mf_b;
  wire        ovf;
  wire        cap_f;
  wire        out_a;
  wire        out_b;
  wire        oe_a;
  wire        oe_b;
  wire        lvl_a;
  wire        lvl_b;
  wire [15:0] ris_a;
  wire [15:0] ris_b;
  wire [15:0] per_a;
  wire [15:0] per_b;
  wire [15:0] hi_a;
  wire [15:0] hi_b;
  integer     n_errors = 0;
  integer     compares = 0;
  integer     k;
  always #10 mclk = ~mclk;
  tpw_top tpw_top_i (
    .mclk(mclk), .srst(srst), .ce(1'b1), .waveform_mode(mode),
    .clock_select(sel), .output_mode_a(om_a), .output_mode_b(om_b),
    .pin_direction_out_a(dir_a), .pin_direction_out_b(1'b1),
    .write_a(wr_en[0]), .write_b(wr_en[1]), .write_capture(wr_en[2]),
    .write_data(wdata), .clear_overflow(1'b0), .clear_match_a(1'b0),
    .clear_match_b(1'b0), .clear_capture(clr_cap), .count_value(cnt),
    .count_down(), .capture_value(cap_v), .overflow_flag(ovf),
    .match_flag_a(), .match_flag_b(mf_b), .capture_flag(cap_f),
    .compare_value_a(cmp_a), .compare_value_b(cmp_b), .compare_out_a(out_a),
    .compare_out_b(out_b), .compare_oe_a(oe_a), .compare_oe_b(oe_b));
  tpw_load tpw_load_i (.mclk(mclk), .pin_out(out_a), .pin_oe(oe_a),
    .level(lvl_a), .rises(ris_a), .period(per_a), .high_time(hi_a));
  tpw_load tpw_load_b_i (.mclk(mclk), .pin_out(out_b), .pin_oe(oe_b),
    .level(lvl_b), .rises(ris_b), .period(per_b), .high_time(hi_b));
  // ==========================================================
  // Tasks
  task chk(input [15:0] e, input [15:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
    end
  endtask
  task wr(input [2:0] w, input [15:0] d);
    begin
      @(negedge mclk);
      wdata = d;
      wr_en = w;
      @(negedge mclk);
      wr_en = 3'h0;
    end
  endtask
  task run(input [3:0] m, input [2:0] s, input [1:0] oa, input [1:0] ob,
           input [15:0] a, input [15:0] b, input [15:0] c);
    begin
      @(negedge mclk);
      srst = 1'b1;
      mode = m;
      sel = 3'h0;
      om_a = oa;
      om_b = ob;
      @(negedge mclk);
      srst = 1'b0;
      wr(3'h4, c);
      wr(3'h1, a);
      wr(3'h2, b);
      @(negedge mclk);
      sel = s;
    end
  endtask
  task meas(input ch, input [15:0] ep, input [15:0] eh);
    reg [15:0] r0;
    integer    n;
    begin
      r0 = ch ? ris_b : ris_a;
      for (n = 0; n < 40000 && (ch ? ris_b : ris_a) < r0 + 16'h0003;
           n = n + 1)
        @(negedge mclk);
      if (n == 40000)
        n_errors = n_errors + 1;
      chk(ep, ch ? per_b : per_a);
      chk(eh, ch ? hi_b : hi_a);
    end
  endtask
  task flat(input ch, input lv);
    reg [15:0] r0;
    begin
      repeat (600) @(negedge mclk);
      r0 = ch ? ris_b : ris_a;
      repeat (600) @(negedge mclk);
      chk(r0, ch ? ris_b : ris_a);
      chk({15'h0000, lv}, {15'h0000, ch ? lvl_b : lvl_a});
    end
  endtask
  function [15:0] nf(input [2:0] s);
    case (s)
      3'h1: nf = 16'd1;
      3'h2: nf = 16'd8;
      3'h3: nf = 16'd64;
      3'h4: nf = 16'd256;
      default: nf = 16'd1024;
    endcase
  endfunction
  task end_of_test;
    begin
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    chk(16'h0000, cnt);
    run(4'h5, 3'h1, 2'h2, 2'h2, 16'h0002, 16'h0000, 16'h0000);
    meas(1'b0, 16'd256, 16'd3);
    meas(1'b1, 16'd256, 16'd1);
    dir_a = 1'b0;
    flat(1'b0, 1'b0);
    chk(16'h0000, {15'h0000, oe_a});
    dir_a = 1'b1;
    for (k = 1; k < 6; k = k + 1) begin
      run(4'hf, k[2:0], 2'h1, 2'h2, 16'h0003, 16'h0001, 16'h0000);
      meas(1'b0, 16'd8 * nf(k[2:0]), 16'd4 * nf(k[2:0]));
      meas(1'b1, 16'd4 * nf(k[2:0]), 16'd2 * nf(k[2:0]));
    end
    run(4'h1, 3'h1, 2'h2, 2'h2, 16'h1264, 16'h0000, 16'h0000);
    meas(1'b0, 16'd510, 16'd200);
    chk(16'h0064, cmp_a);
    flat(1'b1, 1'b0);
    run(4'h1, 3'h1, 2'h3, 2'h3, 16'h00ff, 16'h0000, 16'h0000);
    flat(1'b0, 1'b0);
    flat(1'b1, 1'b1);
    run(4'ha, 3'h1, 2'h0, 2'h2, 16'h0000, 16'h000a, 16'h0014);
    meas(1'b1, 16'd40, 16'd20);
    clr_cap = 1'b1;
    @(negedge mclk);
    clr_cap = 1'b0;
    repeat (60) @(negedge mclk);
    chk(16'h0001, {15'h0000, cap_f});
    chk(16'h0001, {15'h0000, ovf});
    chk(16'h0014, cap_v);
    chk(16'h000a, cmp_b);
    chk(16'h0001, {15'h0000, mf_b});
    run(4'hb, 3'h1, 2'h1, 2'h0, 16'h0014, 16'h0000, 16'h0000);
    meas(1'b0, 16'd80, 16'd40);
    run(4'h8, 3'h1, 2'h2, 2'h2, 16'h0000, 16'h0014, 16'h0014);
    flat(1'b0, 1'b0);
    flat(1'b1, 1'b1);
    run(4'h9, 3'h1, 2'h1, 2'h3, 16'h0014, 16'h000a, 16'h0000);
    meas(1'b0, 16'd80, 16'd40);
    meas(1'b1, 16'd40, 16'd20);
    end_of_test;
  end
  initial begin
    #1900000;
    n_errors = n_errors + 1;
    end_of_test;
  end
endmodule // tb
